//--- rtl/tmr_pkg.sv
// Shared constants for the timer module common core
package tmr_pkg;
    // Register offsets on the plain register port
    localparam logic [3:0] OFF_CTRL0 = 4'h0;
    localparam logic [3:0] OFF_CTRL1 = 4'h1;
    localparam logic [3:0] OFF_PFS0 = 4'h2;
    localparam logic [3:0] OFF_PFS1 = 4'h3;
    localparam logic [3:0] OFF_CNT_L = 4'h4;
    localparam logic [3:0] OFF_CNT_H = 4'h5;
    localparam logic [3:0] OFF_CMPA_L = 4'h6;
    localparam logic [3:0] OFF_CMPA_H = 4'h7;
    localparam logic [3:0] OFF_CMPB_L = 4'h8;
    localparam logic [3:0] OFF_CMPB_H = 4'h9;
    localparam logic [3:0] OFF_CMPP_L = 4'hA;
    localparam logic [3:0] OFF_CMPP_H = 4'hB;
    localparam logic [3:0] OFF_STATUS = 4'hC;
    localparam logic [3:0] OFF_MASK = 4'hD;
    // Control 0 fields: run, edge select, clock source
    localparam int CTRL0_RUN = 7;
    localparam int CTRL0_EDGE = 3;
    localparam int CTRL0_SRC_LO = 0;
    // Control 1 fields: clear source, output action, output enable
    localparam int CTRL1_CLR_LO = 5;
    localparam int CTRL1_ACT_LO = 2;
    localparam int CTRL1_OEN = 0;
    // Reset values
    localparam logic [7:0] CTRL0_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] PFS0_RST = 8'h91;
    localparam logic [7:0] PFS1_RST = 8'h11;
    // Prescaler ratios for the internal sources; the core divides the high clock by 64, not HIGH_DIV
    localparam int SYS_DIV = 4;
    localparam int HIGH_DIV = 16;
    // Status bit positions
    localparam int ST_A = 0;
    localparam int ST_B = 1;
    localparam int ST_P = 2;
    // Clock source codes
    localparam logic [2:0] SRC_SYS4 = 3'h0;
    localparam logic [2:0] SRC_SYS = 3'h1;
    localparam logic [2:0] SRC_HIGH = 3'h2;
    localparam logic [2:0] SRC_HIGH64 = 3'h3;
    localparam logic [2:0] SRC_TBC = 3'h4;
    localparam logic [2:0] SRC_RSVD = 3'h5;
    localparam logic [2:0] SRC_EXT_R = 3'h6;
    localparam logic [2:0] SRC_EXT_R2 = 3'h7;
    // Output actions on a match
    typedef enum logic [1:0] {
        ACT_HOLD, ACT_LOW, ACT_HIGH, ACT_TOGGLE
    } out_act_t;
endpackage

//--- rtl/byte_latch.sv
// Split register with a low-byte staging buffer for an 8-bit bus
`timescale 1ns/1ps
module byte_latch #(
    parameter int W = 16
) (
    input wire logic i_clock, // System clock
    input wire logic i_resetn, // Synchronous reset, low
    input wire logic i_wr_lo, // Write to low byte
    input wire logic i_wr_hi, // Write to high byte
    input wire logic i_rd_hi, // Read of high byte
    input wire logic [7:0] i_wdata, // Write data
    input wire logic [W-1:0] i_live, // Live value to snapshot
    output logic [W-1:0] o_value, // Committed value
    output logic o_commit, // One-cycle pulse on commit
    output logic [7:0] o_buf // Staging buffer
);
    logic [7:0] buf_ff;
    logic [W-1:0] val_ff;
    logic com_ff;

    initial begin
        if (W < 9 || W > 16) $error("byte_latch width must be 9..16");
    end

    // Low byte parks in the buffer; high byte access moves it
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            buf_ff <= 8'h00;
            val_ff <= '0;
            com_ff <= 1'b0;
        end else begin
            com_ff <= i_wr_hi;
            if (i_wr_lo)
                buf_ff <= i_wdata;
            else if (i_rd_hi)
                buf_ff <= i_live[7:0];
            if (i_wr_hi)
                val_ff <= {i_wdata[W-9:0], buf_ff};
        end
    end

    assign o_value = val_ff;
    assign o_commit = com_ff;
    assign o_buf = buf_ff;
endmodule // byte_latch

//--- rtl/tmr_core.sv
// Timer module common core: counter, comparators, pins, registers
//
// Notes on behaviour
// - Free-running counter compared with programmed comparators on each counting step.
// - Match raises interrupt, may clear counter and change output pin.
// - Three-bit field picks system, high, time-base or external clock.
// - Reserved source code 101 gives the counter no clock.
// - External pin source counts its edges, as clock or events.
// - External pin reaches counter only when the source field picks it.
// - External pin active edge is rising or falling, selectable.
// - Compact and standard timers: comparators A and P interrupts.
// - Enhanced timer: comparators A, B and P, each own interrupt.
// - Match output mode drives enabled pin high, low or toggles.
// - PWM waveform appears on the same output pins.
// - Pin select bit one routes pin to timer, zero leaves it.
// - Low byte goes through buffer; moved on high-byte access.
`timescale 1ns/1ps
module tmr_core
    import tmr_pkg::*;
#(
    parameter int CW = 10, // Counter width, 10 or 16
    parameter bit ENHANCED = 1'b1 // Comparator B present
) (
    input wire logic i_clock, // 50 MHz system clock
    input wire logic i_resetn, // Synchronous reset, low
    input wire logic [3:0] i_addr, // Register address
    input wire logic [7:0] i_wdata, // Write data
    input wire logic i_wr, // Write strobe
    input wire logic i_rd, // Read strobe
    output logic [7:0] o_rdata, // Read data, cycle after read
    input wire logic i_timebase_clk, // Time-base clock, sampled
    input wire logic i_high_clk, // High clock, sampled
    input wire logic i_timer_ext_clk_pin, // External clock input
    input wire logic [7:0] i_other_func, // Other pin functions
    output logic [7:0] o_timer_out_pin, // Muxed output pins
    output logic o_ext_clk_routed, // External pin owned by timer
    output logic o_irq // Level interrupt
);
    logic [7:0] ctrl0_ff, ctrl1_ff, pfs0_ff, pfs1_ff;
    logic [2:0] status_ff, mask_ff;
    logic [CW-1:0] cnt_ff, nxt_cnt;
    logic [5:0] pre_ff, hpre_ff;
    logic ext_ff, tbc_ff, hck_ff;
    logic out_ff;
    logic [7:0] rdata_ff, pins_ff;
    logic irq_ff, route_ff;
    logic [CW-1:0] cmp_a, cmp_b, cmp_p;
    logic [7:0] buf_a, buf_b, buf_p;
    logic com_a, com_b, com_p;
    logic [7:0] cnt_buf_ff;

    initial begin
        if (CW != 10 && CW != 16) $error("tmr_core CW must be 10 or 16");
    end

    // Address decode
    wire wr_c0 = i_wr && i_addr == OFF_CTRL0;
    wire wr_c1 = i_wr && i_addr == OFF_CTRL1;
    wire wr_p0 = i_wr && i_addr == OFF_PFS0;
    wire wr_p1 = i_wr && i_addr == OFF_PFS1;
    wire wr_st = i_wr && i_addr == OFF_STATUS;
    wire wr_mk = i_wr && i_addr == OFF_MASK;
    wire rd_ch = i_rd && i_addr == OFF_CNT_H;

    // Comparator storage with low-byte buffers
    byte_latch #(.W(CW)) u_cmpa (
        .i_clock(i_clock), .i_resetn(i_resetn),
        .i_wr_lo(i_wr && i_addr == OFF_CMPA_L),
        .i_wr_hi(i_wr && i_addr == OFF_CMPA_H),
        .i_rd_hi(i_rd && i_addr == OFF_CMPA_H),
        .i_wdata(i_wdata), .i_live(cmp_a),
        .o_value(cmp_a), .o_commit(com_a), .o_buf(buf_a)
    );
    byte_latch #(.W(CW)) u_cmpb (
        .i_clock(i_clock), .i_resetn(i_resetn),
        .i_wr_lo(i_wr && i_addr == OFF_CMPB_L),
        .i_wr_hi(i_wr && i_addr == OFF_CMPB_H),
        .i_rd_hi(i_rd && i_addr == OFF_CMPB_H),
        .i_wdata(i_wdata), .i_live(cmp_b),
        .o_value(cmp_b), .o_commit(com_b), .o_buf(buf_b)
    );
    byte_latch #(.W(CW)) u_cmpp (
        .i_clock(i_clock), .i_resetn(i_resetn),
        .i_wr_lo(i_wr && i_addr == OFF_CMPP_L),
        .i_wr_hi(i_wr && i_addr == OFF_CMPP_H),
        .i_rd_hi(i_rd && i_addr == OFF_CMPP_H),
        .i_wdata(i_wdata), .i_live(cmp_p),
        .o_value(cmp_p), .o_commit(com_p), .o_buf(buf_p)
    );

    // Clock source selection; each source but the reserved code 101 yields a one-cycle tick
    wire [2:0] clk_src_sel = ctrl0_ff[CTRL0_SRC_LO +: 3];
    wire run = ctrl0_ff[CTRL0_RUN];
    wire ext_sel = clk_src_sel[2:1] == SRC_EXT_R[2:1];
    wire ext_rise = i_timer_ext_clk_pin && !ext_ff;
    wire ext_fall = !i_timer_ext_clk_pin && ext_ff;
    wire ext_tick = ctrl0_ff[CTRL0_EDGE] ? ext_fall : ext_rise;
    wire tbc_tick = i_timebase_clk && !tbc_ff;
    wire hck_tick = i_high_clk && !hck_ff;
    wire pre4 = pre_ff[1:0] == 2'h3;
    logic tick;
    always_comb begin
        case (clk_src_sel)
            SRC_SYS4: tick = pre4;
            SRC_SYS: tick = 1'b1;
            SRC_HIGH: tick = hck_tick;
            SRC_HIGH64: tick = hck_tick && hpre_ff == 6'h3F;
            SRC_TBC: tick = tbc_tick;
            SRC_RSVD: tick = 1'b0;
            SRC_EXT_R, SRC_EXT_R2: tick = ext_tick;
            default: tick = 1'b0;
        endcase
    end
    wire step = run && tick;

    // Compare matches, only judged on a counting step
    wire m_a = step && cnt_ff == cmp_a;
    wire m_b = step && ENHANCED && cnt_ff == cmp_b;
    wire m_p = step && cnt_ff == cmp_p;
    wire [1:0] clr_sel = ctrl1_ff[CTRL1_CLR_LO +: 2];
    wire do_clr = (clr_sel == 2'h1 && m_a) || (clr_sel == 2'h2 && m_p)
        || (clr_sel == 2'h3 && m_b);
    wire [2:0] events = {m_p, m_b, m_a};

    // Counter next value: wraps naturally, clears on chosen match
    always_comb begin
        nxt_cnt = cnt_ff;
        if (!run)
            nxt_cnt = '0;
        else if (do_clr)
            nxt_cnt = '0;
        else if (step)
            nxt_cnt = cnt_ff + 1'b1;
    end

    // Output level: comparator A acts, comparator P restores in PWM
    out_act_t act;
    assign act = out_act_t'(ctrl1_ff[CTRL1_ACT_LO +: 2]);
    logic nxt_out;
    always_comb begin
        nxt_out = out_ff;
        if (m_a) begin
            case (act)
                ACT_LOW: nxt_out = 1'b0;
                ACT_HIGH: nxt_out = 1'b1;
                ACT_TOGGLE: nxt_out = !out_ff;
                default: nxt_out = out_ff;
            endcase
        end else if (m_p && act == ACT_HIGH) begin
            nxt_out = 1'b0;
        end
    end

    // Pin routing: select bit picks timer level or other function
    wire tout = out_ff && ctrl1_ff[CTRL1_OEN];
    wire [7:0] nxt_pins = (pfs0_ff & {8{tout}})
        | (~pfs0_ff & i_other_func);

    // Read mux; counter high read snapshots low byte
    logic [7:0] rmux;
    always_comb begin
        case (i_addr)
            OFF_CTRL0: rmux = ctrl0_ff;
            OFF_CTRL1: rmux = ctrl1_ff;
            OFF_PFS0: rmux = pfs0_ff;
            OFF_PFS1: rmux = pfs1_ff;
            OFF_CNT_L: rmux = cnt_buf_ff;
            OFF_CNT_H: rmux = 8'(cnt_ff >> 8);
            OFF_CMPA_L: rmux = buf_a;
            OFF_CMPA_H: rmux = 8'(cmp_a >> 8);
            OFF_CMPB_L: rmux = buf_b;
            OFF_CMPB_H: rmux = 8'(cmp_b >> 8);
            OFF_CMPP_L: rmux = buf_p;
            OFF_CMPP_H: rmux = 8'(cmp_p >> 8);
            OFF_STATUS: rmux = {5'h00, status_ff};
            OFF_MASK: rmux = {5'h00, mask_ff};
            default: rmux = 8'h00;
        endcase
    end

    // Status: hardware set wins over write-one clear
    wire [2:0] clr_w = wr_st ? i_wdata[2:0] : 3'h0;
    wire [2:0] nxt_status = (status_ff & ~clr_w) | events;

    // Edge samples and prescalers; the high ratio counts high-clock
    // edges, since the free system prescaler may never line up with them
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            ext_ff <= 1'b0;
            tbc_ff <= 1'b0;
            hck_ff <= 1'b0;
            pre_ff <= 6'h00;
            hpre_ff <= 6'h00;
        end else begin
            ext_ff <= i_timer_ext_clk_pin;
            tbc_ff <= i_timebase_clk;
            hck_ff <= i_high_clk;
            pre_ff <= pre_ff + 6'h01;
            if (hck_tick) hpre_ff <= hpre_ff + 6'h01;
        end
    end

    // Configuration registers
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            ctrl0_ff <= CTRL0_RST;
            ctrl1_ff <= CTRL1_RST;
            pfs0_ff <= PFS0_RST;
            pfs1_ff <= PFS1_RST;
            mask_ff <= 3'h0;
        end else begin
            if (wr_c0) ctrl0_ff <= i_wdata;
            if (wr_c1) ctrl1_ff <= i_wdata;
            if (wr_p0) pfs0_ff <= i_wdata;
            if (wr_p1) pfs1_ff <= i_wdata;
            if (wr_mk) mask_ff <= i_wdata[2:0];
        end
    end

    // Counter, output, status and port registers
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            cnt_ff <= '0;
            cnt_buf_ff <= 8'h00;
            out_ff <= 1'b0;
            status_ff <= 3'h0;
            rdata_ff <= 8'h00;
            pins_ff <= 8'h00;
            irq_ff <= 1'b0;
            route_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            if (rd_ch) cnt_buf_ff <= cnt_ff[7:0];
            out_ff <= nxt_out;
            status_ff <= nxt_status;
            rdata_ff <= i_rd ? rmux : 8'h00;
            pins_ff <= nxt_pins;
            irq_ff <= |(nxt_status & mask_ff);
            route_ff <= ext_sel;
        end
    end

    assign o_rdata = rdata_ff;
    assign o_timer_out_pin = pins_ff;
    assign o_ext_clk_routed = route_ff;
    assign o_irq = irq_ff;

    // Matches set the status bit on the next edge
    a_match_sets_status: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        m_a |=> status_ff[ST_A])
        else $error("match A did not set status");
    a_p_sets_status: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        m_p |=> status_ff[ST_P])
        else $error("match P did not set status");
    a_b_sets_status: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        m_b |=> status_ff[ST_B])
        else $error("match B did not set status");
    a_clear_on_match: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        do_clr |=> cnt_ff == '0)
        else $error("counter not cleared on match");
    a_count_step: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        (step && !do_clr && !wr_c0) |=> cnt_ff == $past(cnt_ff) + 1'b1)
        else $error("counter did not step");
    a_reserved_idle: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        (clk_src_sel == SRC_RSVD && run && !wr_c0) |=> $stable(cnt_ff))
        else $error("counter moved with reserved source");
    a_ext_gated: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        1'b1 |=> o_ext_clk_routed == $past(ext_sel))
        else $error("external pin routing flag wrong");
    a_toggle_out: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        (m_a && act == ACT_TOGGLE) |=> out_ff != $past(out_ff))
        else $error("output did not toggle");
    a_pin_route: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        !pfs0_ff[0] |=> pins_ff[0] == $past(i_other_func[0]))
        else $error("unselected pin not left to other function");
    a_irq_level: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        ##1 o_irq == |($past(nxt_status) & $past(mask_ff)))
        else $error("interrupt level mismatch");

    // Stopped timer holds its counter at zero
    a_stop_clears: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        !run |=> cnt_ff == '0)
        else $error("stopped counter not at zero");
    a_hi_snapshot: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        rd_ch |=> cnt_buf_ff == $past(cnt_ff[7:0]))
        else $error("counter low byte not snapshotted");
    a_high_action: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        (m_a && act == ACT_HIGH) |=> out_ff)
        else $error("output not driven high on match");
    a_pwm_restore: assert property (
        @(posedge i_clock) disable iff (!i_resetn)
        (m_p && !m_a && act == ACT_HIGH) |=> !out_ff)
        else $error("output not restored on period match");
endmodule // tmr_core

//--- tb/ext_source.sv
// Far-side model: external clock pin that makes one edge per request
`timescale 1ns/1ps
module ext_source (
    input wire logic i_clock, // System clock
    input wire logic i_resetn, // Synchronous reset, low
    input wire logic i_step, // Request one level change
    input wire logic [3:0] i_delay, // Cycles to wait before it
    output logic o_pin, // Level on the timer clock pin
    output logic o_done // Pulse once the edge is made
);
    logic [3:0] wait_ff;
    logic busy_ff;
    // Slow answers keep the level stable for the pin sampler
    always_ff @(posedge i_clock) begin
        o_done <= 1'b0;
        if (!i_resetn) begin
            o_pin <= 1'b0;
            busy_ff <= 1'b0;
            wait_ff <= 4'h0;
        end else if (i_step && !busy_ff) begin
            busy_ff <= 1'b1;
            wait_ff <= i_delay;
        end else if (busy_ff && wait_ff != 4'h0) begin
            wait_ff <= wait_ff - 4'h1;
        end else if (busy_ff) begin
            o_pin <= ~o_pin;
            busy_ff <= 1'b0;
            o_done <= 1'b1;
        end
    end
endmodule // ext_source

//--- tb/tmr_core_test.sv
// Self-checking bench for the timer common core
`timescale 1ns/1ps
module tmr_core_test;
    import tmr_pkg::*;
    logic i_resetn, i_wr, i_rd;
    logic i_clock = 1'b0;
    logic i_high_clk = 1'b0;
    logic i_timebase_clk = 1'b0;
    logic [3:0] i_addr, delay;
    logic [7:0] i_wdata, i_other_func, o_rdata, o_timer_out_pin;
    logic o_ext_clk_routed, o_irq, ext_pin, step, step_done;
    logic [1:0] tb_div = 2'h0;
    int error_cnt, checks_done;

    tmr_core #(.CW(10), .ENHANCED(1'b1)) dut_u (.i_clock(i_clock),
        .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_timebase_clk(i_timebase_clk), .i_high_clk(i_high_clk),
        .i_timer_ext_clk_pin(ext_pin), .i_other_func(i_other_func),
        .o_timer_out_pin(o_timer_out_pin),
        .o_ext_clk_routed(o_ext_clk_routed), .o_irq(o_irq));
    ext_source src_u (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_step(step), .i_delay(delay), .o_pin(ext_pin),
        .o_done(step_done));

    // System clock plus two slower sampled clocks
    always #10 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        i_high_clk <= ~i_high_clk;
        tb_div <= tb_div + 2'h1;
        i_timebase_clk <= tb_div[1];
    end

    task report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task chk(input logic [15:0] seen, exp, input string m);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t %s: %h not %h", $time, m, seen, exp);
        end
    endtask

    // A bound that runs out ends the run at once
    task fail(input string m);
        error_cnt++;
        $display("CHECK FAILED %0t %s", $time, m);
        report_and_stop();
    endtask

    // One-cycle strobes, an idle edge between requests
    task wr(input logic [3:0] a, input logic [7:0] d);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clock);
        i_wr <= 1'b0;
        @(posedge i_clock);
    endtask

    task rd(input logic [3:0] a, output logic [7:0] d);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clock);
        i_rd <= 1'b0;
        @(negedge i_clock);
        d = o_rdata;
        @(posedge i_clock);
    endtask

    task rchk(input logic [3:0] a, input logic [7:0] e, input string m);
        logic [7:0] d;
        rd(a, d);
        chk({8'h00, d}, {8'h00, e}, m);
    endtask

    // Low byte first, the high byte commits the pair
    task wr16(input logic [3:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + 4'h1, v[15:8]);
    endtask

    // High read snapshots the low byte for the next read
    task rd_cnt(output logic [15:0] v);
        logic [7:0] h, l;
        rd(OFF_CNT_H, h);
        rd(OFF_CNT_L, l);
        v = {h, l};
    endtask

    task wait_st(input logic [7:0] m);
        logic [7:0] d;
        for (int n = 0; n < 100; n++) begin
            rd(OFF_STATUS, d);
            if ((d & m) === m) return;
        end
        fail("status never set");
    endtask

    task ext_edge(input logic [3:0] dl);
        delay <= dl;
        step <= 1'b1;
        @(posedge i_clock);
        step <= 1'b0;
        for (int n = 0; n < 20; n++) begin
            @(posedge i_clock);
            if (step_done === 1'b1) return;
        end
        fail("pin model stuck");
    endtask

    // Length of the next whole span with pin 0 at lv
    task hold_len(input logic lv, output int len);
        int n;
        for (n = 0; n < 40 && o_timer_out_pin[0] === lv; n++)
            @(posedge i_clock);
        for (n = 0; n < 40 && o_timer_out_pin[0] !== lv; n++)
            @(posedge i_clock);
        for (len = 0; len < 40 && o_timer_out_pin[0] === lv; len++)
            @(posedge i_clock);
    endtask

    task t_reset;
        rchk(OFF_CTRL0, CTRL0_RST, "ctrl0 reset");
        rchk(OFF_CTRL1, CTRL1_RST, "ctrl1 reset");
        rchk(OFF_PFS0, 8'h91, "pfs0 reset");
        rchk(OFF_PFS1, 8'h11, "pfs1 reset");
        rchk(OFF_MASK, 8'h00, "mask reset");
        rchk(4'hE, 8'h00, "unmapped read");
        $display("test reset done");
    endtask

    task t_pins;
        chk(o_timer_out_pin, 8'h24, "pins at reset");
        wr(OFF_PFS0, 8'h00);
        @(negedge i_clock);
        chk(o_timer_out_pin, 8'hA5, "pins released");
        @(posedge i_clock);
        i_other_func <= 8'h5A;
        repeat (2) @(posedge i_clock);
        chk(o_timer_out_pin, 8'h5A, "other function");
        wr(OFF_PFS0, 8'hFF);
        @(negedge i_clock);
        chk(o_timer_out_pin, 8'h00, "pins taken");
        @(posedge i_clock);
        wr(OFF_PFS1, 8'h22);
        rchk(OFF_PFS1, 8'h22, "pfs1 stored");
        $display("test pins done");
    endtask

    task t_bytes;
        wr16(OFF_CMPA_L, 16'h0123);
        rchk(OFF_CMPA_H, 8'h01, "cmp high");
        rchk(OFF_CMPA_L, 8'h23, "cmp low");
        wr(OFF_CMPA_L, 8'h45);
        rchk(OFF_CMPA_H, 8'h01, "high kept");
        rchk(OFF_CMPA_L, 8'h23, "buffer reloaded");
        $display("test bytes done");
    endtask

    task t_sources;
        logic [15:0] v;
        for (int c = 0; c < 8; c++) begin
            wr(OFF_CTRL0, 8'(c));
            @(negedge i_clock);
            chk(16'(o_ext_clk_routed), 16'(c >= 6), "routing");
            @(posedge i_clock);
            wr(OFF_CTRL0, 8'h80 | 8'(c));
            repeat (300) @(posedge i_clock);
            rd_cnt(v);
            chk(16'(v != 16'h0), 16'(c < 5), "source ticks");
        end
        wr(OFF_CTRL0, 8'h00);
        $display("test sources done");
    endtask

    task t_ext;
        logic [15:0] v;
        wr(OFF_CTRL0, 8'h86);
        ext_edge(4'h0);
        ext_edge(4'h9);
        ext_edge(4'h2);
        repeat (4) @(posedge i_clock);
        rd_cnt(v);
        chk(v, 16'h0002, "rising edges");
        wr(OFF_CTRL0, 8'h0E);
        wr(OFF_CTRL0, 8'h8E);
        ext_edge(4'h5);
        repeat (4) @(posedge i_clock);
        rd_cnt(v);
        chk(v, 16'h0001, "falling edge");
        wr(OFF_CTRL0, 8'h00);
        $display("test external done");
    endtask

    task t_match;
        logic [15:0] v;
        int n;
        wr16(OFF_CMPA_L, 16'h0005);
        wr16(OFF_CMPP_L, 16'h03FF);
        wr(OFF_STATUS, 8'h07);
        wr(OFF_MASK, 8'h01);
        wr(OFF_PFS0, 8'h01);
        wr(OFF_CTRL1, 8'h2D);
        wr(OFF_CTRL0, 8'h81);
        for (n = 0; n < 30 && o_irq !== 1'b1; n++) @(posedge i_clock);
        if (n == 30) fail("no match interrupt");
        hold_len(1'b1, n);
        chk(16'(n), 16'd6, "toggle high span");
        hold_len(1'b0, n);
        chk(16'(n), 16'd6, "toggle low span");
        rd_cnt(v);
        chk(16'(v <= 16'h5), 16'h1, "cleared on match");
        wr(OFF_CTRL0, 8'h01);
        wr(OFF_STATUS, 8'h07);
        rchk(OFF_STATUS, 8'h00, "status cleared");
        chk(16'(o_irq), 16'h0, "irq dropped");
        wr(OFF_MASK, 8'h00);
        wr(OFF_CTRL0, 8'h81);
        wait_st(8'h01);
        chk(16'(o_irq), 16'h0, "masked irq");
        wr(OFF_CTRL0, 8'h01);
        $display("test match done");
    endtask

    task act_run(input logic [7:0] ctl, exp);
        wr(OFF_CTRL1, ctl);
        wr(OFF_CTRL0, 8'h81);
        repeat (20) @(posedge i_clock);
        wr(OFF_CTRL0, 8'h01);
        chk({8'h00, o_timer_out_pin}, {8'h00, exp}, "pin action");
    endtask

    task t_pwm;
        int n;
        wr(OFF_PFS0, 8'hFF);
        wr16(OFF_CMPA_L, 16'h0003);
        act_run(8'h29, 8'hFF);
        act_run(8'h21, 8'hFF);
        act_run(8'h25, 8'h00);
        wr16(OFF_CMPA_L, 16'h0002);
        wr16(OFF_CMPB_L, 16'h0004);
        wr16(OFF_CMPP_L, 16'h0007);
        wr(OFF_STATUS, 8'h07);
        wr(OFF_MASK, 8'h07);
        wr(OFF_CTRL1, 8'h49);
        wr(OFF_CTRL0, 8'h81);
        wait_st(8'h07);
        chk(16'(o_irq), 16'h1, "irq from three");
        hold_len(1'b1, n);
        chk(16'(n), 16'd5, "pwm high span");
        hold_len(1'b0, n);
        chk(16'(n), 16'd3, "pwm low span");
        $display("test pwm done");
    endtask

    initial begin
        i_resetn = 1'b0;
        {i_wr, i_rd, step} = 3'h0;
        {i_addr, delay} = 8'h00;
        i_wdata = 8'h00;
        i_other_func = 8'hA5;
        repeat (3) @(posedge i_clock);
        i_resetn <= 1'b1;
        @(posedge i_clock);
        t_reset();
        t_pins();
        t_bytes();
        t_sources();
        t_ext();
        t_match();
        t_pwm();
        report_and_stop();
    end
endmodule // tmr_core_test
